// *** include/ccio_pkg.sv ***
package ccio_pkg;

  localparam int unsigned NUM_CH   = 8;
  localparam int unsigned CNT_W    = 16;
  localparam int unsigned NUM_CTL  = 4;

  // Byte addresses of the APB registers.
  localparam logic [7:0] ADDR_CTL_AB  = 8'h00;
  localparam logic [7:0] ADDR_CTL_CD  = 8'h04;
  localparam logic [7:0] ADDR_CTL_EF  = 8'h08;
  localparam logic [7:0] ADDR_CTL_GH  = 8'h0c;
  localparam logic [7:0] ADDR_GR_BASE = 8'h20;
  localparam logic [7:0] ADDR_PINS    = 8'h40;

  // Field positions within a control register.
  localparam int unsigned LO_SEL_LSB = 0;
  localparam int unsigned HI_SEL_LSB = 4;
  localparam logic [7:0]  CTL_MASK   = 8'h77;
  localparam logic [7:0]  CTL_RESET  = 8'h00;

  // Selector encodings.
  typedef enum logic [2:0] {
    CCIO_OFF       = 3'b000,
    CCIO_OUT_LOW   = 3'b001,
    CCIO_OUT_HIGH  = 3'b010,
    CCIO_OUT_TOG   = 3'b011,
    CCIO_CAP_NONE  = 3'b100,
    CCIO_CAP_RISE  = 3'b101,
    CCIO_CAP_FALL  = 3'b110,
    CCIO_CAP_BOTH  = 3'b111
  } ccio_sel_e;

  // Full state of the block.
  typedef struct packed {
    logic [NUM_CTL-1:0][7:0]       ctl;
    logic [NUM_CH-1:0][CNT_W-1:0]  gr;
    logic [NUM_CH-1:0]             pin_out;
    logic [NUM_CH-1:0]             pin_oe;
    logic [NUM_CH-1:0]             pin_prev;
    logic [NUM_CH-1:0]             capture;
    logic [31:0]                   prdata;
    logic                          pready;
  } ccio_state_s;

endpackage

// *** logic/ccio_ch2.sv ***
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ns
module ccio_ch2 (
  input  wire logic                                          clk,
  input  wire logic                                          reset,
  input  wire logic                                          standby,
  input  wire logic                                          psel,
  input  wire logic                                          penable,
  input  wire logic                                          pwrite,
  input  wire logic [7:0]                                    paddr,
  input  wire logic [31:0]                                   pwdata,
  output logic      [31:0]                                   prdata,
  output logic                                               pready,
  output logic                                               pslverr,
  input  wire logic [ccio_pkg::CNT_W-1:0]                    counter,
  input  wire logic [ccio_pkg::NUM_CH-1:0]                   match,
  input  wire logic [ccio_pkg::NUM_CH-1:0]                   ch2_timer_pin_in,
  output logic      [ccio_pkg::NUM_CH-1:0]                   ch2_timer_pin_out,
  output logic      [ccio_pkg::NUM_CH-1:0]                   ch2_timer_pin_oe,
  output logic      [ccio_pkg::NUM_CH-1:0]                   capture_pulse,
  output logic      [ccio_pkg::NUM_CH*ccio_pkg::CNT_W-1:0]   ch2_cc_regs
);

  ccio_pkg::ccio_state_s s_q;
  ccio_pkg::ccio_state_s s_d;

  logic [2:0]                  sel [ccio_pkg::NUM_CH];
  logic                        bus_setup;
  logic                        bus_access;
  logic                        bus_wr;
  logic                        bus_rd;
  logic [ccio_pkg::NUM_CH-1:0] pin_rise;
  logic [ccio_pkg::NUM_CH-1:0] pin_fall;
  logic [ccio_pkg::NUM_CH-1:0] gr_wr_ok;
  logic [ccio_pkg::NUM_CH-1:0] cap_hit;

  // Bus phase strobes. A write commits only at the access edge where pready is high, so a
  // master that abandons a transfer after setup never leaves a half-written register.
  always_comb begin
    bus_setup  = psel && !penable;
    bus_access = psel && penable && s_q.pready;
    bus_wr     = bus_access && pwrite;
    bus_rd     = bus_setup && !pwrite;
  end

  // Channel k uses ctl[k/2]; even channels (A,C,E,G) the low field, odd (B,D,F,H) the high.
  always_comb begin
    for (int k = 0; k < ccio_pkg::NUM_CH; k++) begin
      if (k[0]) begin
        sel[k] = s_q.ctl[k/2][ccio_pkg::HI_SEL_LSB +: 3];
      end else begin
        sel[k] = s_q.ctl[k/2][ccio_pkg::LO_SEL_LSB +: 3];
      end
    end
  end

  // Pin edges against last cycle's sample, write permission and the capture decision.
  // The previous sample resets low, so a pin already high at reset looks like a rising edge.
  always_comb begin
    for (int k = 0; k < ccio_pkg::NUM_CH; k++) begin
      pin_rise[k] = ch2_timer_pin_in[k] && !s_q.pin_prev[k];
      pin_fall[k] = !ch2_timer_pin_in[k] && s_q.pin_prev[k];
      // Edge-capture modes lock out software so a captured value is never overwritten.
      gr_wr_ok[k] = !(sel[k][2] && sel[k][1:0] != 2'h0);
      case (ccio_pkg::ccio_sel_e'(sel[k]))
        ccio_pkg::CCIO_CAP_RISE: begin
          cap_hit[k] = pin_rise[k];
        end
        ccio_pkg::CCIO_CAP_FALL: begin
          cap_hit[k] = pin_fall[k];
        end
        ccio_pkg::CCIO_CAP_BOTH: begin
          cap_hit[k] = pin_rise[k] || pin_fall[k];
        end
        default: begin
          cap_hit[k] = 1'b0;
        end
      endcase
    end
  end

  // Next-state logic: bus access, compare actions and capture.
  always_comb begin
    s_d          = s_q;
    s_d.pready   = bus_setup;
    s_d.capture  = '0;
    s_d.pin_prev = ch2_timer_pin_in;

    // Register writes land at the access edge, together with the master's pready sample.
    if (bus_wr) begin
      if (paddr == ccio_pkg::ADDR_CTL_AB) begin
        s_d.ctl[0] = pwdata[7:0] & ccio_pkg::CTL_MASK;
      end else if (paddr == ccio_pkg::ADDR_CTL_CD) begin
        s_d.ctl[1] = pwdata[7:0] & ccio_pkg::CTL_MASK;
      end else if (paddr == ccio_pkg::ADDR_CTL_EF) begin
        s_d.ctl[2] = pwdata[7:0] & ccio_pkg::CTL_MASK;
      end else if (paddr == ccio_pkg::ADDR_CTL_GH) begin
        s_d.ctl[3] = pwdata[7:0] & ccio_pkg::CTL_MASK;
      end else begin
        // General registers sit one word apart from the base; unmapped writes drop.
        for (int k = 0; k < ccio_pkg::NUM_CH; k++) begin
          if (paddr == ccio_pkg::ADDR_GR_BASE + 8'(4 * k) && gr_wr_ok[k]) begin
            s_d.gr[k] = pwdata[ccio_pkg::CNT_W-1:0];
          end
        end
      end
    end

    // Read data is registered at the setup edge and stands with pready in the access cycle.
    if (bus_rd) begin
      s_d.prdata = 32'h0;
      if (paddr == ccio_pkg::ADDR_CTL_AB) begin
        s_d.prdata = {24'h0, s_q.ctl[0]};
      end else if (paddr == ccio_pkg::ADDR_CTL_CD) begin
        s_d.prdata = {24'h0, s_q.ctl[1]};
      end else if (paddr == ccio_pkg::ADDR_CTL_EF) begin
        s_d.prdata = {24'h0, s_q.ctl[2]};
      end else if (paddr == ccio_pkg::ADDR_CTL_GH) begin
        s_d.prdata = {24'h0, s_q.ctl[3]};
      end else if (paddr == ccio_pkg::ADDR_PINS) begin
        s_d.prdata = {24'h0, s_q.pin_out};
      end else begin
        for (int k = 0; k < ccio_pkg::NUM_CH; k++) begin
          if (paddr == ccio_pkg::ADDR_GR_BASE + 8'(4 * k)) begin
            s_d.prdata = {{(32-ccio_pkg::CNT_W){1'b0}}, s_q.gr[k]};
          end
        end
      end
    end

    // Per-channel compare action; the pin is driven only in the three compare modes.
    for (int k = 0; k < ccio_pkg::NUM_CH; k++) begin
      s_d.pin_oe[k] = !sel[k][2] && sel[k] != 3'h0;
      case (ccio_pkg::ccio_sel_e'(sel[k]))
        ccio_pkg::CCIO_OUT_LOW: begin
          if (match[k]) begin
            s_d.pin_out[k] = 1'b0;
          end
        end
        ccio_pkg::CCIO_OUT_HIGH: begin
          if (match[k]) begin
            s_d.pin_out[k] = 1'b1;
          end
        end
        ccio_pkg::CCIO_OUT_TOG: begin
          if (match[k]) begin
            s_d.pin_out[k] = !s_q.pin_out[k];
          end
        end
        default: begin
          s_d.pin_out[k] = s_q.pin_out[k];
        end
      endcase
      // A capture beats a software write in the same cycle.
      s_d.capture[k] = cap_hit[k];
      if (cap_hit[k]) begin
        s_d.gr[k] = counter;
      end
    end

    // Standby holds every control register at zero.
    if (standby) begin
      for (int r = 0; r < ccio_pkg::NUM_CTL; r++) begin
        s_d.ctl[r] = ccio_pkg::CTL_RESET;
      end
    end
  end

  // State register.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata            = s_q.prdata;
  assign pready            = s_q.pready;
  assign pslverr           = 1'b0;
  assign ch2_timer_pin_out = s_q.pin_out;
  assign ch2_timer_pin_oe  = s_q.pin_oe;
  assign capture_pulse     = s_q.capture;
  assign ch2_cc_regs       = s_q.gr;

endmodule

// *** bench/ccio_ch2_properties.sv ***
`timescale 1ns/1ns
module ccio_ch2_properties (
  input wire logic         clk,
  input wire logic         reset,
  input wire logic         standby,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [7:0]   paddr,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic [15:0]  counter,
  input wire logic [7:0]   match,
  input wire logic [7:0]   ch2_timer_pin_in,
  input wire logic [7:0]   ch2_timer_pin_out,
  input wire logic [7:0]   ch2_timer_pin_oe,
  input wire logic [7:0]   capture_pulse,
  input wire logic [127:0] ch2_cc_regs
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // Capture edges are judged against the two pin samples before the pulse.
  property p_rdy; psel && !penable |=> pready && penable; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_rsv; pready && !pwrite && paddr < 8'h10 |-> (prdata & 32'hffffff88) == 0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved control bits set");
  property p_stb; standby ##1 standby |=> ch2_timer_pin_oe == 8'h00; endproperty
  a_stb: assert property (p_stb) else $error("standby left a pin driven");
  property p_mode; (ch2_timer_pin_oe & capture_pulse) == 8'h00; endproperty
  a_mode: assert property (p_mode) else $error("capture on a compare lane");
  property p_out; (($past(ch2_timer_pin_out) ^ ch2_timer_pin_out) & ~$past(match)) == 8'h00;
  endproperty
  a_out: assert property (p_out) else $error("pin moved without match");
  property p_edge; (capture_pulse & ~($past(ch2_timer_pin_in) ^ $past(ch2_timer_pin_in, 2)))
    == 8'h00; endproperty
  a_edge: assert property (p_edge) else $error("capture without pin edge");
  property p_capv; capture_pulse[3] |-> ch2_cc_regs[63:48] == $past(counter); endproperty
  a_capv: assert property (p_capv) else $error("wrong captured value");
  property p_acc; pready |-> psel && penable; endproperty
  a_acc: assert property (p_acc) else $error("ready outside access");
endmodule

// *** bench/ccio_pin_model.sv ***
`timescale 1ns/1ns
module ccio_pin_model (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_level,
  output logic      [7:0] pin_in
);
  // A driven pin shows the block's level, an undriven one the far side's.
  always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// *** bench/test_ccio_ch2.sv ***
`timescale 1ns/1ns
module test_ccio_ch2;
  logic         clk = 0, reset = 1, standby = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]   paddr = 0, match = 0, ext = 0, ch2_timer_pin_in;
  logic [7:0]   ch2_timer_pin_out, ch2_timer_pin_oe, capture_pulse;
  logic [15:0]  counter = 0;
  logic [31:0]  pwdata = 0, prdata, q;
  logic         pready, pslverr;
  logic [127:0] ch2_cc_regs;
  int           err_total = 0, checks = 0;
  ccio_ch2 DUT (.*);
  ccio_pin_model u_pins (.pin_out(ch2_timer_pin_out), .pin_oe(ch2_timer_pin_oe),
    .ext_level(ext), .pin_in(ch2_timer_pin_in));
  // Clock and a watchdog sized well beyond the fewer than one hundred cycles used.
  always #50 clk = ~clk;
  initial begin
    #200000;
    err_total++;
    stop_test();
  end
  task automatic chk(input string s, input logic [63:0] g, input logic [63:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  // One APB transfer; the request holds until ready is sampled high.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rc(input string s, input logic [7:0] a, input logic [63:0] e);
    bus(0, a, 0);
    chk(s, q, e);
  endtask
  task automatic pulse(input logic [7:0] m);
    match <= m;
    @(posedge clk);
    match <= 0;
    repeat (2) @(posedge clk);
  endtask
  task automatic t_reg();
    for (int i = 0; i < 4; i++) begin
      rc("ctl_reset", 8'(4 * i), 0);
      bus(1, 8'(4 * i), 32'h77);
      rc("ctl_rw", 8'(4 * i), 32'h77);
    end
    rc("unmapped", 8'h44, 0);
    chk("slverr", pslverr, 0);
  endtask
  // B toggles from low while A is driven high, then B toggles back and A goes low.
  task automatic t_cmp();
    bus(1, 8'h00, 32'h32);
    pulse(8'h03);
    chk("pin_high", {ch2_timer_pin_oe[1:0], ch2_timer_pin_out[1:0]}, 4'hf);
    rc("pin_rb", 8'h40, 32'h03);
    bus(1, 8'h00, 32'h31);
    pulse(8'h03);
    chk("pin_low", ch2_timer_pin_out[1:0], 0);
  endtask
  task automatic t_cap();
    bus(1, 8'h04, 32'h56);
    counter <= 16'h1234;
    ext <= 8'h1c;
    repeat (3) @(posedge clk);
    chk("cap_rise", ch2_cc_regs[79:32], 48'h1234_1234_0000);
    bus(1, 8'h2c, 32'h0);
    counter <= 16'h0abc;
    ext <= 8'h00;
    repeat (3) @(posedge clk);
    chk("cap_fall", ch2_cc_regs[79:32], 48'h0abc_1234_0abc);
    bus(1, 8'h0c, 32'h04);
    bus(1, 8'h38, 32'h5555);
    rc("cap_none_wr", 8'h38, 32'h5555);
  endtask
  task automatic t_stby();
    standby <= 1;
    repeat (2) @(posedge clk);
    standby <= 0;
    rc("stby_ctl", 8'h00, 0);
    chk("stby_oe", ch2_timer_pin_oe, 0);
  endtask
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    reset <= 0;
    t_reg();
    t_cmp();
    t_cap();
    t_stby();
    stop_test();
  end
endmodule
bind ccio_ch2 ccio_ch2_properties u_chk (.*);
